// *** shared/lgacm_defines.svh ***
// Register offsets, field positions, reset values and timing counts of the legacy gain bank.
`ifndef LGACM_DEFINES_SVH
`define LGACM_DEFINES_SVH
`define LGACM_ADDR_W        7
`define LGACM_DATA_W        9
`define LGACM_OFF_LGAIN     7'h00
`define LGACM_OFF_RGAIN     7'h01
`define LGACM_OFF_LPATH     7'h02
`define LGACM_OFF_RPATH     7'h03
`define LGACM_OFF_CONV      7'h05
`define LGACM_OFF_NLGAIN    7'h4D
`define LGACM_OFF_NRGAIN    7'h4E
`define LGACM_OFF_EQX       7'h68
`define LGACM_OFF_SPINOTCH  7'h69
`define LGACM_OFF_MANIN     7'h6A
`define LGACM_OFF_MANVMID   7'h6B
`define LGACM_OFF_LSWING    7'h6C
`define LGACM_OFF_RSWING    7'h6D
`define LGACM_OFF_LPEAK     7'h6E
`define LGACM_OFF_RPEAK     7'h6F
`define LGACM_OFF_FLAGS     7'h70
`define LGACM_OFF_BUFTIE    7'h71
`define LGACM_RST_EQX       9'h006
`define LGACM_RST_ZERO      9'h000
`define LGACM_APPLY_BIT     8
`define LGACM_S1GAIN_HI     6
`define LGACM_S1GAIN_LO     5
`define LGACM_S1EN_BIT      4
`define LGACM_POL_HI        6
`define LGACM_POL_LO        5
`define LGACM_HALFCUR_BIT   2
`define LGACM_HPBYP_BIT     0
`define LGACM_NMUTE_BIT     6
`define LGACM_LOWCLAMP      8'hAB
`define LGACM_NATIVE_MAX    6'h38
`define LGACM_MCLK_TIMEOUT  4'h8
`endif

// *** shared/lgacm_pkg.sv ***
// Types shared by the legacy gain bank modules.
package lgacm_pkg;
    typedef logic [8:0] lgacm_word_t;
    typedef logic [5:0] lgacm_native_t;
endpackage

// *** core/lgacm_gain_map.sv ***
// Combinational translation of a legacy gain code to a native gain code.
`timescale 1ns/10ps
`include "lgacm_defines.svh"
module lgacm_gain_map
    import lgacm_pkg::*;
(
    // Legacy code in.
    input  wire logic [7:0]    code,
    // Native code and mute out.
    output lgacm_native_t      native,
    output logic               mute
);
    // Legacy gain in half dB is (v-195); native gain in quarter dB is 3n-48.
    // Smallest n with 3n-48 >= 2(v-195) gives n = ceil((2v-342)/3).
    logic signed [11:0] num;
    logic        [11:0] quo;

    // Zero code mutes; low codes clamp to the bottom native step.
    always_comb begin
        num  = 12'(signed'({4'h0, code}) * 2) - 12'sd342;
        quo  = 12'((num + 12'sd2) / 12'sd3);
        mute = (code == 8'h00);
        if (code <= `LGACM_LOWCLAMP || num <= 12'sd0) begin
            native = 6'h00;
        end else if (quo > 12'(`LGACM_NATIVE_MAX)) begin
            native = `LGACM_NATIVE_MAX;
        end else begin
            native = quo[5:0];
        end
    end

    chk_map_zero_mute: assert final (!(code == 8'h00) || mute) else $error("zero code not muted");
    chk_map_codes: assert final (!(code == 8'hFE) || native == 6'h38) else $error("code 254 wrong");
    chk_map_range: assert final (native <= 6'h38) else $error("native out of range");
endmodule

// *** core/lgacm_bank.sv ***
// Legacy compatibility register bank with gain translation and option outputs.
`timescale 1ns/10ps
`include "lgacm_defines.svh"
module lgacm_bank
    import lgacm_pkg::*;
(
    // Clock and synchronous reset.
    input  wire logic              clk,
    input  wire logic              rstn,
    // Register port from the serial control decoder.
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    input  wire logic [6:0]        addr,
    input  wire lgacm_word_t       wdata,
    output lgacm_word_t            rdata,
    output logic                   rvalid,
    // Master clock pin, sampled as a level.
    input  wire logic              mclk_pin,
    // Readout sources from the level detectors.
    input  wire lgacm_word_t       left_swing_in,
    input  wire lgacm_word_t       right_swing_in,
    input  wire lgacm_word_t       left_peak_in,
    input  wire lgacm_word_t       right_peak_in,
    input  wire lgacm_word_t       flags_in,
    // Native gain controls.
    output lgacm_native_t          left_native_gain,
    output lgacm_native_t          right_native_gain,
    output logic                   left_pga_mute_assert,
    output logic                   right_pga_mute_assert,
    // First-stage controls.
    output logic [1:0]             left_stage1_gain,
    output logic [1:0]             right_stage1_gain,
    output logic                   left_stage1_enable,
    output logic                   right_stage1_enable,
    // Converter options.
    output logic                   invert_left,
    output logic                   invert_right,
    output logic                   half_current_select,
    output logic                   highpass_bypass
);
    // Storage of the legacy and tail registers.
    lgacm_word_t  lgain;              // Left legacy gain word.
    lgacm_word_t  rgain;              // Right legacy gain word.
    lgacm_word_t  lpath;              // Left input path word.
    lgacm_word_t  rpath;              // Right input path word.
    lgacm_word_t  conv;               // Converter options word.
    lgacm_word_t  eqx;                // Extra equaliser control.
    lgacm_word_t  spinotch;           // Serial and notch control.
    lgacm_word_t  manin;              // Manual input tie-off.
    lgacm_word_t  manvmid;            // Manual mid-reference tie-off.
    lgacm_word_t  buftie;             // Buffer tie-off control.
    // Pending apply requests, held until the master clock is seen running.
    logic         lpend;
    logic         rpend;
    // Master clock synchroniser and activity detector.
    logic         mclk_s1;
    logic         mclk_s2;
    logic         mclk_s3;
    logic [3:0]   idle_cnt;
    logic         mclk_run;

    // Decoded write strobes and the master clock edge.
    wire w_lgain   = wr_en && addr == `LGACM_OFF_LGAIN;
    wire w_rgain   = wr_en && addr == `LGACM_OFF_RGAIN;
    wire w_nlgain  = wr_en && addr == `LGACM_OFF_NLGAIN;
    wire w_nrgain  = wr_en && addr == `LGACM_OFF_NRGAIN;
    wire mclk_edge = mclk_s2 ^ mclk_s3;

    // Translated codes from the current legacy words.
    lgacm_native_t lmap_code;
    lgacm_native_t rmap_code;
    logic          lmap_mute;
    logic          rmap_mute;

    // Left channel translator.
    lgacm_gain_map u_lmap (
        .code   (lgain[7:0]),
        .native (lmap_code),
        .mute   (lmap_mute)
    );

    // Right channel translator.
    lgacm_gain_map u_rmap (
        .code   (rgain[7:0]),
        .native (rmap_code),
        .mute   (rmap_mute)
    );

    // Next-value of the pending flags: a new apply write sets, application clears.
    wire next_lpend = (w_lgain && wdata[`LGACM_APPLY_BIT]) || (lpend && !mclk_run);
    wire next_rpend = (w_rgain && wdata[`LGACM_APPLY_BIT]) || (rpend && !mclk_run);
    wire lapply     = lpend && mclk_run;
    wire rapply     = rpend && mclk_run;

    // Read multiplexer; unmapped addresses read as zero.
    lgacm_word_t next_rdata;
    always_comb begin
        if (addr == `LGACM_OFF_LGAIN) begin
            next_rdata = lgain;
        end else if (addr == `LGACM_OFF_RGAIN) begin
            next_rdata = rgain;
        end else if (addr == `LGACM_OFF_LPATH) begin
            next_rdata = lpath;
        end else if (addr == `LGACM_OFF_RPATH) begin
            next_rdata = rpath;
        end else if (addr == `LGACM_OFF_CONV) begin
            next_rdata = conv;
        end else if (addr == `LGACM_OFF_NLGAIN) begin
            // Native view shows the current native gain and mute, whether applied or written.
            next_rdata = {2'b00, left_pga_mute_assert, left_native_gain};
        end else if (addr == `LGACM_OFF_NRGAIN) begin
            next_rdata = {2'b00, right_pga_mute_assert, right_native_gain};
        end else if (addr == `LGACM_OFF_EQX) begin
            next_rdata = eqx;
        end else if (addr == `LGACM_OFF_SPINOTCH) begin
            next_rdata = spinotch;
        end else if (addr == `LGACM_OFF_MANIN) begin
            next_rdata = manin;
        end else if (addr == `LGACM_OFF_MANVMID) begin
            next_rdata = manvmid;
        end else if (addr == `LGACM_OFF_LSWING) begin
            next_rdata = left_swing_in;
        end else if (addr == `LGACM_OFF_RSWING) begin
            next_rdata = right_swing_in;
        end else if (addr == `LGACM_OFF_LPEAK) begin
            next_rdata = left_peak_in;
        end else if (addr == `LGACM_OFF_RPEAK) begin
            next_rdata = right_peak_in;
        end else if (addr == `LGACM_OFF_FLAGS) begin
            next_rdata = flags_in;
        end else if (addr == `LGACM_OFF_BUFTIE) begin
            next_rdata = buftie;
        end else begin
            next_rdata = 9'h000;
        end
    end

    // Master clock synchroniser; only the second and third stages are examined.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mclk_s1 <= 1'b0;
            mclk_s2 <= 1'b0;
            mclk_s3 <= 1'b0;
        end else begin
            mclk_s1 <= mclk_pin;
            mclk_s2 <= mclk_s1;
            mclk_s3 <= mclk_s2;
        end
    end

    // Activity detector: the clock counts as running from an edge until it is quiet too long.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            idle_cnt <= 4'h0;
            mclk_run <= 1'b0;
        end else if (mclk_edge) begin
            idle_cnt <= 4'h0;
            mclk_run <= 1'b1;
        end else if (idle_cnt != `LGACM_MCLK_TIMEOUT) begin
            idle_cnt <= idle_cnt + 4'h1;
        end else begin
            mclk_run <= 1'b0;
        end
    end

    // Legacy register writes; the apply bit is kept as written.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lgain <= `LGACM_RST_ZERO;
            rgain <= `LGACM_RST_ZERO;
            lpath <= `LGACM_RST_ZERO;
            rpath <= `LGACM_RST_ZERO;
            conv  <= `LGACM_RST_ZERO;
        end else if (wr_en) begin
            if (w_lgain) lgain <= wdata;
            if (w_rgain) rgain <= wdata;
            if (addr == `LGACM_OFF_LPATH) lpath <= wdata;
            if (addr == `LGACM_OFF_RPATH) rpath <= wdata;
            if (addr == `LGACM_OFF_CONV) conv <= wdata;
        end
    end

    // Tail register writes.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            eqx      <= `LGACM_RST_EQX;
            spinotch <= `LGACM_RST_ZERO;
            manin    <= `LGACM_RST_ZERO;
            manvmid  <= `LGACM_RST_ZERO;
            buftie   <= `LGACM_RST_ZERO;
        end else if (wr_en) begin
            if (addr == `LGACM_OFF_EQX) eqx <= wdata;
            if (addr == `LGACM_OFF_SPINOTCH) spinotch <= wdata;
            if (addr == `LGACM_OFF_MANIN) manin <= wdata;
            if (addr == `LGACM_OFF_MANVMID) manvmid <= wdata;
            if (addr == `LGACM_OFF_BUFTIE) buftie <= wdata;
        end
    end

    // Pending apply flags and read answer.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lpend  <= 1'b0;
            rpend  <= 1'b0;
            rdata  <= 9'h000;
            rvalid <= 1'b0;
        end else begin
            lpend  <= next_lpend;
            rpend  <= next_rpend;
            rdata  <= rd_en ? next_rdata : rdata;
            rvalid <= rd_en;
        end
    end

    // Native gain state: an apply loads the mapping, a native write overrides it.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            left_native_gain      <= 6'h00;
            right_native_gain     <= 6'h00;
            left_pga_mute_assert  <= 1'b0;
            right_pga_mute_assert <= 1'b0;
        end else begin
            if (w_nlgain) begin
                left_native_gain     <= wdata[5:0];
                left_pga_mute_assert <= wdata[`LGACM_NMUTE_BIT];
            end else if (lapply) begin
                left_native_gain     <= lmap_code;
                left_pga_mute_assert <= lmap_mute;
            end
            if (w_nrgain) begin
                right_native_gain     <= wdata[5:0];
                right_pga_mute_assert <= wdata[`LGACM_NMUTE_BIT];
            end else if (rapply) begin
                right_native_gain     <= rmap_code;
                right_pga_mute_assert <= rmap_mute;
            end
        end
    end

    // Path and converter option outputs, registered from the legacy words.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            left_stage1_gain    <= 2'b00;
            right_stage1_gain   <= 2'b00;
            left_stage1_enable  <= 1'b0;
            right_stage1_enable <= 1'b0;
            invert_left         <= 1'b0;
            invert_right        <= 1'b0;
            half_current_select <= 1'b0;
            highpass_bypass     <= 1'b0;
        end else begin
            left_stage1_gain    <= lpath[`LGACM_S1GAIN_HI:`LGACM_S1GAIN_LO];
            right_stage1_gain   <= rpath[`LGACM_S1GAIN_HI:`LGACM_S1GAIN_LO];
            left_stage1_enable  <= lpath[`LGACM_S1EN_BIT];
            right_stage1_enable <= rpath[`LGACM_S1EN_BIT];
            invert_left         <= conv[`LGACM_POL_LO];
            invert_right        <= conv[`LGACM_POL_HI];
            half_current_select <= conv[`LGACM_HALFCUR_BIT];
            highpass_bypass     <= conv[`LGACM_HPBYP_BIT];
        end
    end

    // Checks of the gain application and option paths.
    chk_gain_applied: assert property (@(posedge clk) disable iff (!rstn)
        lapply && !w_nlgain |=> left_native_gain == $past(lmap_code))
        else $error("left gain not applied");
    chk_noclk_hold: assert property (@(posedge clk) disable iff (!rstn)
        !mclk_run && !w_nlgain |=> $stable(left_native_gain))
        else $error("gain changed without master clock");
    chk_apply_pend: assert property (@(posedge clk) disable iff (!rstn)
        w_rgain && wdata[`LGACM_APPLY_BIT] |=> rpend)
        else $error("apply request lost");
    chk_mute_zero: assert property (@(posedge clk) disable iff (!rstn)
        rapply && !w_nrgain && rgain[7:0] == 8'h00 |=> right_pga_mute_assert)
        else $error("zero code not muted");
    chk_boost_field: assert property (@(posedge clk) disable iff (!rstn)
        ##1 left_stage1_gain == $past(lpath[6:5]))
        else $error("boost field mismatch");
    chk_enable_bit: assert property (@(posedge clk) disable iff (!rstn)
        ##1 right_stage1_enable == $past(rpath[4]))
        else $error("stage enable mismatch");
    chk_polarity_map: assert property (@(posedge clk) disable iff (!rstn)
        ##1 {invert_right, invert_left} == $past(conv[6:5]))
        else $error("polarity mismatch");
    chk_current_hpf: assert property (@(posedge clk) disable iff (!rstn)
        ##1 half_current_select == $past(conv[2]) && highpass_bypass == $past(conv[0]))
        else $error("converter option mismatch");
    chk_no_backmap: assert property (@(posedge clk) disable iff (!rstn)
        w_nlgain |=> $stable(lgain))
        else $error("native write reflected");
    chk_hpf_bit: assert property (@(posedge clk) disable iff (!rstn)
        wr_en && addr == `LGACM_OFF_CONV ##2 1'b1 |-> highpass_bypass == $past(wdata[0], 2))
        else $error("bypass bit not followed");

    // Main scenarios.
    cov_apply_left: cover property (@(posedge clk) disable iff (!rstn) lapply);
    cov_wait_clock: cover property (@(posedge clk) disable iff (!rstn) lpend && !mclk_run ##1 lapply);
    cov_native_override: cover property (@(posedge clk) disable iff (!rstn) w_nrgain);
endmodule

// *** bench/test_legacy_gain_adc_ctrl_map.sv ***
// Self-checking register-level testbench for the legacy gain bank.
`timescale 1ns/10ps
`include "lgacm_defines.svh"
module test_legacy_gain_adc_ctrl_map
    import lgacm_pkg::*;
;
    // Clock, reset and register port stimulus.
    logic          clk, rstn, wr_en, rd_en, mclk_pin, mclk_run;
    logic [6:0]    addr;
    lgacm_word_t   wdata, rdata, val;
    logic          rvalid;
    // Readout sources, held at distinct constants.
    lgacm_word_t   left_swing_in, right_swing_in, left_peak_in, right_peak_in, flags_in;
    // Design outputs.
    lgacm_native_t left_native_gain, right_native_gain;
    logic          left_pga_mute_assert, right_pga_mute_assert;
    logic [1:0]    left_stage1_gain, right_stage1_gain;
    logic          left_stage1_enable, right_stage1_enable;
    logic          invert_left, invert_right, half_current_select, highpass_bypass;
    // Scoreboard counters.
    int            failures, comparisons, cycles;

    lgacm_bank DUT (.clk, .rstn, .wr_en, .rd_en, .addr, .wdata, .rdata, .rvalid, .mclk_pin,
        .left_swing_in, .right_swing_in, .left_peak_in, .right_peak_in, .flags_in,
        .left_native_gain, .right_native_gain, .left_pga_mute_assert, .right_pga_mute_assert,
        .left_stage1_gain, .right_stage1_gain, .left_stage1_enable, .right_stage1_enable,
        .invert_left, .invert_right, .half_current_select, .highpass_bypass);

    // Free-running 50 MHz clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // The master clock pin toggles every cycle while enabled, so the bank sees it running.
    always @(posedge clk) begin
        if (mclk_run) begin
            mclk_pin <= ~mclk_pin;
        end
    end

    // Cycle counter cuts a hang short well above the expected run length.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            wrap_up();
        end
    end

    // Compares two words and reports a mismatch at once.
    task automatic chk(input lgacm_word_t got, input lgacm_word_t exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe, taken at the following edge.
    task automatic wr(input logic [6:0] a, input lgacm_word_t d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // One-cycle read strobe; data and valid are taken one cycle later.
    task automatic rd(input logic [6:0] a, output lgacm_word_t d);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk({8'h00, rvalid}, 9'h001);
        d = rdata;
    endtask

    // Lets a number of edges pass, then steps off the edge.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Expected native code: smallest code whose gain reaches the legacy gain, clamped.
    function automatic lgacm_native_t map_exp(input int v);
        int n;
        if (v <= 171) begin
            return 6'h00;
        end
        n = (2 * v - 340) / 3;
        return (n > 56) ? 6'h38 : n[5:0];
    endfunction

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        int codes [9];
        int c;
        logic [1:0] b;
        lgacm_word_t ro_exp [5];
        codes = '{0, 1, 171, 172, 173, 194, 200, 203, 254};
        {rstn, wr_en, rd_en, mclk_pin, mclk_run} = 5'h00;
        addr = 7'h00;
        wdata = 9'h000;
        left_swing_in = 9'h111;
        right_swing_in = 9'h0A2;
        left_peak_in = 9'h1C3;
        right_peak_in = 9'h054;
        flags_in = 9'h1E5;
        ro_exp = '{9'h111, 9'h0A2, 9'h1C3, 9'h054, 9'h1E5};
        failures = 0;
        comparisons = 0;
        cycles = 0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        mclk_run <= 1'b1;
        // Reset values and access kinds.
        rd(`LGACM_OFF_EQX, val);
        chk(val, `LGACM_RST_EQX);
        rd(`LGACM_OFF_CONV, val);
        chk(val, `LGACM_RST_ZERO);
        for (int i = 0; i < 4; i++) begin
            c = (i == 3) ? 7'h71 : 7'h69 + i;
            wr(c[6:0], 9'h1A5 ^ 9'(i));
            rd(c[6:0], val);
            chk(val, 9'h1A5 ^ 9'(i));
        end
        for (int i = 0; i < 5; i++) begin
            wr(`LGACM_OFF_LSWING + 7'(i), 9'h000);
            rd(`LGACM_OFF_LSWING + 7'(i), val);
            chk(val, ro_exp[i]);
        end
        wr(7'h04, 9'h1FF);
        rd(7'h04, val);
        chk(val, 9'h000);
        // Gain code translation on both channels, including mute and anchors.
        for (int i = 0; i < 9; i++) begin
            wr(`LGACM_OFF_LGAIN, {1'b1, codes[i][7:0]});
            wr(`LGACM_OFF_RGAIN, {1'b1, codes[8 - i][7:0]});
            settle(2);
            chk({3'h0, left_native_gain}, {3'h0, map_exp(codes[i])});
            chk({3'h0, right_native_gain}, {3'h0, map_exp(codes[8 - i])});
            chk({7'h00, left_pga_mute_assert, right_pga_mute_assert},
                {7'h00, codes[i] == 0, codes[8 - i] == 0});
        end
        // Apply flag clear: code stored but native gain untouched.
        wr(`LGACM_OFF_LGAIN, 9'h0AC);
        settle(4);
        chk({3'h0, left_native_gain}, 9'h038);
        rd(`LGACM_OFF_LGAIN, val);
        chk(val, 9'h0AC);
        // Stopped master clock holds the apply until the clock returns.
        @(posedge clk);
        mclk_run <= 1'b0;
        settle(14);
        wr(`LGACM_OFF_LGAIN, 9'h1CB);
        settle(8);
        chk({3'h0, left_native_gain}, 9'h038);
        @(posedge clk);
        mclk_run <= 1'b1;
        for (int i = 0; i < 20 && left_native_gain !== 6'h16; i++) begin
            settle(1);
        end
        chk({3'h0, left_native_gain}, 9'h016);
        // Native overwrite wins and never reaches the legacy register.
        wr(`LGACM_OFF_NLGAIN, 9'h045);
        settle(2);
        chk({2'h0, left_pga_mute_assert, left_native_gain}, 9'h045);
        rd(`LGACM_OFF_NLGAIN, val);
        chk(val, 9'h045);
        rd(`LGACM_OFF_LGAIN, val);
        chk(val, 9'h1CB);
        // The right native register is overwritten the same way; its legacy word keeps the last code.
        wr(`LGACM_OFF_NRGAIN, 9'h02A);
        settle(2);
        chk({2'h0, right_pga_mute_assert, right_native_gain}, 9'h02A);
        rd(`LGACM_OFF_NRGAIN, val);
        chk(val, 9'h02A);
        rd(`LGACM_OFF_RGAIN, val);
        chk(val, 9'h100);
        // First-stage boost and enable, channels set differently.
        for (int i = 0; i < 4; i++) begin
            b = i[1:0];
            wr(`LGACM_OFF_LPATH, {2'h0, b, b[0], 4'h0});
            wr(`LGACM_OFF_RPATH, {2'h0, ~b, ~b[0], 4'h0});
            settle(2);
            chk({3'h0, left_stage1_gain, left_stage1_enable, right_stage1_gain, right_stage1_enable},
                {3'h0, b, b[0], ~b, ~b[0]});
        end
        // Polarity, half current and high-pass bypass options.
        for (int i = 0; i < 4; i++) begin
            b = i[1:0];
            wr(`LGACM_OFF_CONV, {2'h0, b, 2'h0, b[0], 1'b0, b[1]});
            settle(2);
            chk({5'h0, invert_right, invert_left, half_current_select, highpass_bypass},
                {5'h0, b[1], b[0], b[0], b[1]});
        end
        wrap_up();
    end
endmodule
